// >>> hw/status_event_aggregator.sv
// Purpose : event flag registers, masks and status byte summaries
// Assumes : parser decodes queries into one-cycle strobes; state inputs are
//           same-clock logic; i_rst_n is power-on reset
// Notes   : a hardware set in the same cycle as a clear wins
//
// Functional notes
// R1 - eight-bit standard event flags; enabled set bit raises status bit 5
// R2 - standard flags clear on clear-status, on their query, and at power-on except bit 7
// R3 - power-up flag bit 7 set on power application or outage recovery
// R4 - user-request bit 6 and request-control bit 1 never set
// R5 - syntax errors set bit 5; rest of message ignored until terminator
// R6 - failed command execution sets run-failure flag bit 4
// R7 - internal device faults set device-fault flag bit 3
// R8 - queue overflow or loss sets bit 2 and clears output queue
// R9 - operation-done bit 0 set when all prior messages completed
// R10 - standard mask bit enables matching flag into summary
// R11 - two sixteen-bit device event registers, each with own mask
// R12 - enabled operation flag raises status byte bit 7
// R13 - enabled questionable flag raises status byte bit 3
// R14 - device event registers clear on clear-status, power-on, own query
// R15 - operation bit 13 set on error, cleared by error-detail query
// R16 - operation bit 11 set when channel closing completes
// R17 - operation bit 10 set while in remote state
// R18 - operation bit 5 set while waiting for trigger
// R19 - operation bit 4 set while scan sequence runs
// R20 - master summary bit 6 rises on enabled status bit rising; request raised
// R21 - power-on clears event registers except power-up flag bit 7
// R22 - summaries are continuous or of flag and mask; reserved bits read zero
`timescale 1ns/100ps
module status_event_aggregator
   import status_event_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // command strobes from the parser
   input  wire logic        i_clear_status,
   input  wire logic        i_std_flags_query,
   input  wire logic        i_oper_flags_query,
   input  wire logic        i_ques_flags_query,
   input  wire logic        i_error_query,
   input  wire logic        i_std_mask_write,
   input  wire logic [7:0]  i_std_mask_data,
   input  wire logic        i_oper_mask_write,
   input  wire logic [15:0] i_oper_mask_data,
   input  wire logic        i_ques_mask_write,
   input  wire logic [15:0] i_ques_mask_data,
   input  wire logic        i_srq_mask_write,
   input  wire logic [7:0]  i_srq_mask_data,
   input  wire logic        i_serial_poll,
   // event sources
   input  wire logic        i_power_recovered,
   input  wire logic        i_syntax_error,
   input  wire logic        i_message_terminator,
   input  wire logic        i_run_failure,
   input  wire logic        i_device_fault,
   input  wire logic        i_queue_overflow,
   input  wire logic        i_queue_data_lost,
   input  wire logic        i_all_ops_done,
   input  wire logic        i_device_error,
   input  wire logic        i_close_done,
   input  wire logic        i_remote_state,
   input  wire logic        i_awaiting_trigger,
   input  wire logic        i_scan_running,
   input  wire logic        i_backup_error,
   input  wire logic        i_info_error,
   input  wire logic        i_message_available,
   input  wire logic        i_error_pending,
   // readback and summaries
   output logic [7:0]       o_standard_event_flags,
   output logic [7:0]       o_standard_event_mask,
   output logic [15:0]      o_operation_event_flags,
   output logic [15:0]      o_operation_event_mask,
   output logic [15:0]      o_questionable_event_flags,
   output logic [15:0]      o_questionable_event_mask,
   output logic [7:0]       o_status_byte,
   output logic [7:0]       o_srq_mask,
   output logic             o_service_request,
   output logic             o_discard_message,
   output logic             o_clear_output_queue
);
   // ****************************************************************
   // registers
   // ****************************************************************
   logic [7:0]  std_flags_reg;
   logic [7:0]  std_flags_next;
   logic [7:0]  std_mask_reg;
   logic [15:0] oper_flags_reg;
   logic [15:0] oper_flags_next;
   logic [15:0] oper_mask_reg;
   logic [15:0] ques_flags_reg;
   logic [15:0] ques_flags_next;
   logic [15:0] ques_mask_reg;
   logic [7:0]  srq_mask_reg;
   logic [7:0]  status_byte_reg;
   logic [7:0]  status_byte_next;
   logic        master_reg;
   logic        srq_reg;
   logic        discard_reg;
   logic        clear_queue_reg;
   logic        std_event_summary;
   logic        operation_summary;
   logic        questionable_summary;
   logic [7:0]  std_set;
   logic [15:0] oper_set;
   logic [15:0] ques_set;
   logic [7:0]  sb_enabled;
   logic        sb_rise;
   // ****************************************************************
   // summary reduction
   // ****************************************************************
   summary_or #(.WIDTH(8)) std_sum (                                 // [R1] [R10]
      .i_flags (std_flags_reg),
      .i_mask  (std_mask_reg),
      .o_any   (std_event_summary)
   );
   summary_or #(.WIDTH(16)) oper_sum (                               // [R12]
      .i_flags (oper_flags_reg),
      .i_mask  (oper_mask_reg),
      .o_any   (operation_summary)
   );
   summary_or #(.WIDTH(16)) ques_sum (                               // [R13]
      .i_flags (ques_flags_reg),
      .i_mask  (ques_mask_reg),
      .o_any   (questionable_summary)
   );
   // ****************************************************************
   // standard event flags
   // ****************************************************************
   always_comb begin
      std_set                      = 8'h00;
      std_set[POWER_UP_BIT]        = i_power_recovered;                 // [R3]
      std_set[COMMAND_SYNTAX_BIT]  = i_syntax_error;                    // [R5]
      std_set[RUN_FAILURE_BIT]     = i_run_failure;                     // [R6]
      std_set[DEVICE_FAULT_BIT]    = i_device_fault;                    // [R7]
      std_set[QUERY_FAULT_BIT]     = i_queue_overflow | i_queue_data_lost; // [R8]
      std_set[OPERATION_DONE_BIT]  = i_all_ops_done;                    // [R9]
      std_flags_next = std_flags_reg;
      if (i_clear_status || i_std_flags_query) begin
         std_flags_next = 8'h00;                                     // [R2]
      end
      std_flags_next = (std_flags_next | std_set) & STD_IMPL_MASK;   // [R4] [R22]
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         std_flags_reg <= STD_FLAGS_RESET;                           // [R2] [R21] [R3]
      end else begin
         std_flags_reg <= std_flags_next;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         std_mask_reg <= STD_MASK_RESET;
      end else if (i_std_mask_write) begin
         std_mask_reg <= i_std_mask_data;                            // [R10]
      end
   end
   // ****************************************************************
   // device-specific event registers
   // ****************************************************************
   always_comb begin
      oper_set                      = 16'h0000;
      oper_set[OP_ERROR_BIT]        = i_device_error;                // [R15]
      oper_set[OP_CLOSE_DONE_BIT]   = i_close_done;                  // [R16]
      oper_set[OP_REMOTE_BIT]       = i_remote_state;                // [R17]
      oper_set[OP_TRIGGER_WAIT_BIT] = i_awaiting_trigger;            // [R18]
      oper_set[OP_SCAN_BIT]         = i_scan_running;                // [R19]
      oper_flags_next = oper_flags_reg;
      if (i_clear_status || i_oper_flags_query) begin
         oper_flags_next = 16'h0000;                                 // [R14]
      end
      if (i_error_query) begin
         oper_flags_next[OP_ERROR_BIT] = 1'b0;                       // [R15]
      end
      oper_flags_next = (oper_flags_next | oper_set) & OPER_IMPL_MASK; // [R11] [R22]
   end
   always_comb begin
      ques_set                    = 16'h0000;
      ques_set[QS_BACKUP_ERR_BIT] = i_backup_error;
      ques_set[QS_INFO_ERR_BIT]   = i_info_error;
      ques_flags_next = ques_flags_reg;
      if (i_clear_status || i_ques_flags_query) begin
         ques_flags_next = 16'h0000;                                 // [R14]
      end
      ques_flags_next = (ques_flags_next | ques_set) & QUES_IMPL_MASK; // [R11] [R22]
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         oper_flags_reg <= EVT_FLAGS_RESET;                          // [R14] [R21]
         ques_flags_reg <= EVT_FLAGS_RESET;
      end else begin
         oper_flags_reg <= oper_flags_next;
         ques_flags_reg <= ques_flags_next;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         oper_mask_reg <= EVT_MASK_RESET;
         ques_mask_reg <= EVT_MASK_RESET;
      end else begin
         if (i_oper_mask_write) begin
            oper_mask_reg <= i_oper_mask_data;                       // [R11]
         end
         if (i_ques_mask_write) begin
            ques_mask_reg <= i_ques_mask_data;                       // [R11]
         end
      end
   end
   // ****************************************************************
   // status byte and service request
   // ****************************************************************
   always_comb begin
      status_byte_next                      = 8'h00;
      status_byte_next[SB_OPER_SUMMARY_BIT] = operation_summary;     // [R12]
      status_byte_next[SB_STD_SUMMARY_BIT]  = std_event_summary;     // [R1]
      status_byte_next[SB_MAV_BIT]          = i_message_available;
      status_byte_next[SB_QUES_SUMMARY_BIT] = questionable_summary;  // [R13]
      status_byte_next[SB_ERROR_BIT]        = i_error_pending;
      sb_enabled = status_byte_next & srq_mask_reg & ~(8'h01 << SB_MASTER_BIT);
      sb_rise    = |(sb_enabled & ~(status_byte_reg & srq_mask_reg)); // [R20]
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         srq_mask_reg <= SRQ_MASK_RESET;
      end else if (i_srq_mask_write) begin
         srq_mask_reg <= i_srq_mask_data;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_byte_reg <= STATUS_BYTE_RESET;
      end else begin
         status_byte_reg <= status_byte_next;
      end
   end
   // master summary holds until clear-status; a new rise wins over the clear
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         master_reg <= 1'b0;
      end else if (sb_rise) begin
         master_reg <= 1'b1;                                         // [R20]
      end else if (i_clear_status) begin
         master_reg <= 1'b0;
      end
   end
   // request is read and cleared by serial poll
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         srq_reg <= 1'b0;
      end else if (sb_rise) begin
         srq_reg <= 1'b1;                                            // [R20]
      end else if (i_serial_poll || i_clear_status) begin
         srq_reg <= 1'b0;
      end
   end
   // ****************************************************************
   // message discard and queue clear
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         discard_reg <= 1'b0;
      end else if (i_syntax_error) begin
         discard_reg <= 1'b1;                                        // [R5]
      end else if (i_message_terminator) begin
         discard_reg <= 1'b0;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         clear_queue_reg <= 1'b0;
      end else begin
         clear_queue_reg <= i_queue_overflow | i_queue_data_lost;    // [R8]
      end
   end
   // ****************************************************************
   // outputs
   // ****************************************************************
   assign o_standard_event_flags     = std_flags_reg;
   assign o_standard_event_mask      = std_mask_reg;
   assign o_operation_event_flags    = oper_flags_reg;
   assign o_operation_event_mask     = oper_mask_reg;
   assign o_questionable_event_flags = ques_flags_reg;
   assign o_questionable_event_mask  = ques_mask_reg;
   assign o_srq_mask                 = srq_mask_reg;
   assign o_service_request          = srq_reg;
   assign o_discard_message          = discard_reg;
   assign o_clear_output_queue       = clear_queue_reg;
   always_comb begin
      o_status_byte                = status_byte_reg;
      o_status_byte[SB_MASTER_BIT] = master_reg;                     // [R20]
   end
endmodule

// >>> hw/status_event_pkg.sv
// Purpose : constants shared by the status event aggregator
// Assumes : command parser decodes queries and writes into strobes
// Notes   : bit positions of event flags and status byte summaries
package status_event_pkg;
   // ****************************************************************
   // standard event flag positions
   // ****************************************************************
   localparam int OPERATION_DONE_BIT  = 0;
   localparam int REQUEST_CONTROL_BIT = 1;
   localparam int QUERY_FAULT_BIT     = 2;
   localparam int DEVICE_FAULT_BIT    = 3;
   localparam int RUN_FAILURE_BIT     = 4;
   localparam int COMMAND_SYNTAX_BIT  = 5;
   localparam int USER_REQUEST_BIT    = 6;
   localparam int POWER_UP_BIT        = 7;
   // ****************************************************************
   // operation event flag positions
   // ****************************************************************
   localparam int OP_SCAN_BIT         = 4;
   localparam int OP_TRIGGER_WAIT_BIT = 5;
   localparam int OP_REMOTE_BIT       = 10;
   localparam int OP_CLOSE_DONE_BIT   = 11;
   localparam int OP_ERROR_BIT        = 13;
   // ****************************************************************
   // questionable event flag positions
   // ****************************************************************
   localparam int QS_BACKUP_ERR_BIT   = 7;
   localparam int QS_INFO_ERR_BIT     = 8;
   // ****************************************************************
   // status byte positions
   // ****************************************************************
   localparam int SB_QUES_SUMMARY_BIT = 3;
   localparam int SB_STD_SUMMARY_BIT  = 5;
   localparam int SB_MASTER_BIT       = 6;
   localparam int SB_OPER_SUMMARY_BIT = 7;
   localparam int SB_MAV_BIT          = 4;
   localparam int SB_ERROR_BIT        = 2;
   // ****************************************************************
   // implemented bits and reset values
   // ****************************************************************
   localparam logic [7:0]  STD_IMPL_MASK  = 8'hBD;
   localparam logic [15:0] OPER_IMPL_MASK = 16'h2C30;
   localparam logic [15:0] QUES_IMPL_MASK = 16'h0180;
   localparam logic [7:0]  STD_FLAGS_RESET = 8'h80;
   localparam logic [7:0]  STD_MASK_RESET  = 8'h00;
   localparam logic [15:0] EVT_MASK_RESET  = 16'h0000;
   localparam logic [7:0]  SRQ_MASK_RESET  = 8'h00;
   localparam logic [15:0] EVT_FLAGS_RESET = 16'h0000;
   localparam logic [7:0]  STATUS_BYTE_RESET = 8'h00;
endpackage

// >>> hw/summary_or.sv
// Purpose : or-reduce event flags gated by an enable mask
// Assumes : flags and mask are registered
// Notes   : purely combinational
`timescale 1ns/100ps
module summary_or #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] i_flags,
   input  wire logic [WIDTH-1:0] i_mask,
   output logic                  o_any
);
   if (WIDTH < 1) begin : gen_bad_width
      $error("summary_or width must be positive");
   end
   logic [WIDTH-1:0] gated;
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : gate_bits
         assign gated[g] = i_flags[g] & i_mask[g];
      end
   endgenerate
   assign o_any = |gated;
endmodule

// >>> tb/remote_controller_model.sv
// Purpose : remote controller issuing one-cycle command strobes
// Assumes : strobe index 0 clear, 1-4 queries, 5-8 mask writes, 9 poll
// Notes   : strobes change only just after a rising edge
`timescale 1ns/100ps
module remote_controller_model (
   input  wire logic        i_clk,
   output logic [9:0]       o_cmd,
   output logic [15:0]      o_data
);
   initial begin
      o_cmd  = 10'h000;
      o_data = 16'h0000;
   end
   task automatic send(input int which, input logic [15:0] data);
      @(posedge i_clk);
      #1;
      o_cmd  = 10'h001 << which;
      o_data = data;
      @(posedge i_clk);
      #1;
      o_cmd  = 10'h000;
      o_data = ~data;
   endtask
endmodule

// >>> tb/status_event_aggregator_assertions.sv
// Purpose : port checker for the status event aggregator
// Assumes : flags move one edge after their cause
// Notes   : summaries lag the flags by one cycle
`timescale 1ns/100ps
module status_event_aggregator_assertions
   import status_event_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic        i_clear_status,
   input wire logic        i_std_flags_query,
   input wire logic        i_error_query,
   input wire logic        i_std_mask_write,
   input wire logic [7:0]  i_std_mask_data,
   input wire logic        i_syntax_error,
   input wire logic        i_message_terminator,
   input wire logic        i_run_failure,
   input wire logic        i_queue_overflow,
   input wire logic        i_queue_data_lost,
   input wire logic        i_device_error,
   input wire logic        i_remote_state,
   input wire logic [7:0]  o_standard_event_flags,
   input wire logic [7:0]  o_standard_event_mask,
   input wire logic [15:0] o_operation_event_flags,
   input wire logic [15:0] o_operation_event_mask,
   input wire logic [7:0]  o_status_byte,
   input wire logic        o_service_request,
   input wire logic        o_discard_message,
   input wire logic        o_clear_output_queue
);
   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_syntax_hit;
      i_syntax_error && !i_message_terminator;
   endsequence
   sequence s_queue_hit;
      i_queue_overflow || i_queue_data_lost;
   endsequence
   chk_unused_bits_zero: assert property (o_standard_event_flags[6] == 1'b0 &&
      o_standard_event_flags[1] == 1'b0 && (o_operation_event_flags & ~OPER_IMPL_MASK) == '0)
      else $error("unused flag bit set");
   chk_std_summary: assert property (!$past(i_clear_status) |-> o_status_byte[5] ==
      |($past(o_standard_event_flags) & $past(o_standard_event_mask)))
      else $error("standard summary wrong");
   chk_oper_summary: assert property (!$past(i_clear_status) |-> o_status_byte[7] ==
      |($past(o_operation_event_flags) & $past(o_operation_event_mask)))
      else $error("operation summary wrong");
   chk_run_fail_set: assert property (i_run_failure |=> o_standard_event_flags[4])
      else $error("run failure flag not set");
   chk_query_clears: assert property (i_std_flags_query |=>
      o_standard_event_flags[4] == $past(i_run_failure))
      else $error("query did not clear flags");
   chk_error_query_clr: assert property (i_error_query && !i_device_error |=>
      !o_operation_event_flags[13]) else $error("error bit not cleared");
   chk_syntax_discard: assert property (s_syntax_hit |=> o_discard_message)
      else $error("message not discarded");
   chk_queue_fault: assert property (s_queue_hit |=>
      o_clear_output_queue && o_standard_event_flags[2]) else $error("queue fault missed");
   chk_remote_level: assert property (i_remote_state |=> o_operation_event_flags[10])
      else $error("remote bit not set");
   chk_mask_write: assert property (i_std_mask_write |=>
      o_standard_event_mask == $past(i_std_mask_data)) else $error("mask not written");
   chk_srq_master: assert property ($rose(o_service_request) |-> o_status_byte[6])
      else $error("request without master summary");
endmodule
bind status_event_aggregator status_event_aggregator_assertions i_chk (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_clear_status(i_clear_status),
   .i_std_flags_query(i_std_flags_query), .i_error_query(i_error_query),
   .i_std_mask_write(i_std_mask_write), .i_std_mask_data(i_std_mask_data),
   .i_syntax_error(i_syntax_error), .i_message_terminator(i_message_terminator),
   .i_run_failure(i_run_failure), .i_queue_overflow(i_queue_overflow),
   .i_queue_data_lost(i_queue_data_lost), .i_device_error(i_device_error),
   .i_remote_state(i_remote_state), .o_standard_event_flags(o_standard_event_flags),
   .o_standard_event_mask(o_standard_event_mask),
   .o_operation_event_flags(o_operation_event_flags),
   .o_operation_event_mask(o_operation_event_mask), .o_status_byte(o_status_byte),
   .o_service_request(o_service_request), .o_discard_message(o_discard_message),
   .o_clear_output_queue(o_clear_output_queue));

// >>> tb/status_event_aggregator_bench.sv
// Purpose : self-checking bench for the status event aggregator
// Assumes : flags and masks visible one edge after their cause
// Notes   : a bit-level model is compared every cycle
`timescale 1ns/100ps
module status_event_aggregator_bench;
   logic        clk, rst_n, mav, errp, srq, disc, cq, chk_on, mm, msr, rise;
   logic [14:0] ev;
   logic [9:0]  cmd;
   logic [15:0] cd, op_f, op_m, qs_f, qs_m, mo, mom, mq, mqm;
   logic [7:0]  std_f, std_m, sb, srq_m, ms, msm, msrq, sbx, sbx_n;
   int          n_fail, n_compared, i;
   remote_controller_model i_remote_controller_model (.i_clk(clk), .o_cmd(cmd), .o_data(cd));
   status_event_aggregator i_status_event_aggregator (
      .i_clk(clk), .i_rst_n(rst_n), .i_clear_status(cmd[0]),
      .i_std_flags_query(cmd[1]), .i_oper_flags_query(cmd[2]),
      .i_ques_flags_query(cmd[3]), .i_error_query(cmd[4]),
      .i_std_mask_write(cmd[5]), .i_std_mask_data(cd[7:0]),
      .i_oper_mask_write(cmd[6]), .i_oper_mask_data(cd),
      .i_ques_mask_write(cmd[7]), .i_ques_mask_data(cd),
      .i_srq_mask_write(cmd[8]), .i_srq_mask_data(cd[7:0]),
      .i_serial_poll(cmd[9]), .i_power_recovered(ev[0]),
      .i_syntax_error(ev[1]), .i_message_terminator(ev[2]),
      .i_run_failure(ev[3]), .i_device_fault(ev[4]),
      .i_queue_overflow(ev[5]), .i_queue_data_lost(ev[6]),
      .i_all_ops_done(ev[7]), .i_device_error(ev[8]),
      .i_close_done(ev[9]), .i_remote_state(ev[10]),
      .i_awaiting_trigger(ev[11]), .i_scan_running(ev[12]),
      .i_backup_error(ev[13]), .i_info_error(ev[14]),
      .i_message_available(mav), .i_error_pending(errp),
      .o_standard_event_flags(std_f), .o_standard_event_mask(std_m),
      .o_operation_event_flags(op_f), .o_operation_event_mask(op_m),
      .o_questionable_event_flags(qs_f), .o_questionable_event_mask(qs_m),
      .o_status_byte(sb), .o_srq_mask(srq_m), .o_service_request(srq),
      .o_discard_message(disc), .o_clear_output_queue(cq));
   // ****************************************************************
   // reference model and checks
   // ****************************************************************
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic cyc(input logic [14:0] e);
      @(posedge clk);
      #1;
      ev = e;
   endtask
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {ms, msm, msrq, sbx, mo, mom, mq, mqm, mm, msr} = {8'h80, 90'h0};
      end else begin
         sbx_n = {|(mo & mom), 1'b0, |(ms & msm), mav, |(mq & mqm), errp, 2'b00};
         rise = |(sbx_n & msrq & ~(sbx & msrq));
         mm = rise | (mm & !cmd[0]);
         msr = rise | (msr & !cmd[0] & !cmd[9]);
         sbx = sbx_n;
         if (cmd[0] || cmd[1]) ms = 8'h00;
         if (cmd[0] || cmd[2]) mo = 16'h0000;
         if (cmd[0] || cmd[3]) mq = 16'h0000;
         if (cmd[4]) mo[13] = 1'b0;
         if (cmd[5]) msm = cd[7:0];
         if (cmd[6]) mom = cd;
         if (cmd[7]) mqm = cd;
         if (cmd[8]) msrq = cd[7:0];
         ms |= {ev[0], 1'b0, ev[1], ev[3], ev[4], ev[5] | ev[6], 1'b0, ev[7]};
         mo |= {2'b00, ev[8], 1'b0, ev[9], ev[10], 4'h0, ev[11], ev[12], 4'h0};
         mq |= {7'h00, ev[14], ev[13], 7'h00};
      end
   end
   always @(negedge clk) begin
      if (chk_on) begin
         cmp16({std_f, std_m}, {ms, msm});
         cmp16(op_f, mo);
         cmp16(qs_f, mq);
         cmp16(op_m, mom);
         cmp16(qs_m, mqm);
         cmp16(16'(srq_m), 16'(msrq));
         cmp16({sb, 7'h00, srq}, {sbx | {1'b0, mm, 6'h00}, 7'h00, msr});
      end
   end
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      {rst_n, mav, errp, chk_on, ev} = '0;
      n_fail = 0;
      n_compared = 0;
      void'($urandom(30));
      repeat (10) @(posedge clk);
      cmp16({std_f, std_m}, 16'h8000);
      cmp16(op_f | qs_f | op_m | qs_m, 16'h0000);
      #1;
      rst_n  = 1'b1;
      chk_on = 1'b1;
      for (i = 5; i < 9; i++) i_remote_controller_model.send(i, 16'hFFFF);
      for (i = 0; i < 15; i++) cyc(15'h0001 << i);
      cyc(15'h0400);
      for (i = 1; i < 5; i++) i_remote_controller_model.send(i, 16'h0000);
      cyc(15'h0100);
      cyc(15'h0000);
      i_remote_controller_model.send(4, 16'h0000);
      i_remote_controller_model.send(0, 16'h0000);
      cyc(15'h0008);
      for (i = 0; i < 8 && srq !== 1'b1; i++) cyc(15'h0000);
      cmp16(16'(srq), 16'h0001);
      if (srq !== 1'b1) test_done();
      i_remote_controller_model.send(9, 16'h0000);
      cyc(15'h0000);
      cmp16(16'(srq), 16'h0000);
      cyc(15'h0002);
      cyc(15'h0000);
      cyc(15'h0000);
      cmp16(16'(disc), 16'h0001);
      cyc(15'h0004);
      cyc(15'h0000);
      cmp16(16'(disc), 16'h0000);
      cyc(15'h0020);
      cyc(15'h0000);
      cmp16(16'(cq), 16'h0001);
      repeat (1500) begin
         cyc(15'($urandom & $urandom & $urandom));
         mav  = 1'($urandom);
         errp = 1'($urandom);
         if ($urandom_range(3) == 0) i_remote_controller_model.send($urandom_range(9), 16'($urandom));
      end
      test_done();
   end
endmodule
